// [rtl/sld_segment_lcd_driver.sv]
// Functional notes
// [R01] Drive 22 segments by up to 8 commons.
// [R02] Display memory bytes 00h-15h, spare ones general-purpose.
// [R03] Byte n is segment n, bit k common k.
// [R04] One selects the dot, zero leaves dark.
// [R05] Memory scanned to segments without processor help.
// [R06] Display memory takes bit and byte accesses.
// [R07] Scan keeps running while the core idles.
// [R08] Control resets to 00h: off, 1/8, 128Hz.
// [R09] Bits 7:5 divide watch clock 256 to 16.
// [R10] Software avoids scan clock codes 101-111.
// [R11] Bits 4:2 select duty and bias.
// [R12] Bits 1:0 select off, blank, all, normal.
// [R13] Control write restarts divider and common sequence.
// [R14] Software keeps watch timer running for display.
// [R15] Scan clock sets the frame repetition rate.
// [R16] Active commons follow the duty setting.
// [R17] Commons visited ascending, segments from matching bit.
`timescale 1ns/1ns

module sld_segment_lcd_driver
  import sld_pkg::*;
#(
  parameter int SEGS = SLD_SEGS,
  parameter int COMS = SLD_COMS
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic watch_clock_in_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_ram_sel_i,
  input wire logic [7:0] cpu_addr_i,
  input wire logic cpu_bit_op_i,
  input wire logic [2:0] cpu_bit_sel_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  output logic [SEGS-1:0] segment_drive_pins_o,
  output logic [COMS-1:0] common_drive_pins_o,
  output logic [1:0] bias_sel_o,
  output logic scan_clock_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] lcd_control;
  logic [7:0] mem [SEGS];
  logic ctrl_wr;
  logic ram_wr;
  logic ram_hit;
  logic [4:0] ram_idx;
  logic [7:0] read_byte;
  sld_mode_t mode;

  assign ram_hit = cpu_ram_sel_i && (cpu_addr_i <= SLD_RAM_LAST); // R02
  assign ram_idx = cpu_addr_i[4:0];
  assign ctrl_wr = cpu_wr_i && !cpu_ram_sel_i &&
                   (cpu_addr_i == SLD_CTRL_OFFSET);
  assign ram_wr = cpu_wr_i && ram_hit;
  assign mode = sld_mode_t'(lcd_control[SLD_MODE_LSB +: 2]);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lcd_control <= SLD_CTRL_RESET; // R08
    end else if (ctrl_wr) begin
      lcd_control <= sld_merge(lcd_control, cpu_wdata_i, cpu_bit_op_i,
                               cpu_bit_sel_i);
    end
  end

  // Display memory has no reset, like ordinary RAM.
  always_ff @(posedge clk_i) begin
    if (ram_wr) begin
      mem[ram_idx] <= sld_merge(mem[ram_idx], cpu_wdata_i, cpu_bit_op_i,
                                cpu_bit_sel_i); // R06
    end
  end

  always_comb begin
    read_byte = 8'h00;
    if (ram_hit) begin
      read_byte = mem[ram_idx];
    end else if (!cpu_ram_sel_i && cpu_addr_i == SLD_CTRL_OFFSET) begin
      read_byte = lcd_control;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpu_rdata_o <= 8'h00;
    end else if (cpu_rd_i) begin
      cpu_rdata_o <= cpu_bit_op_i ? {7'h00, read_byte[cpu_bit_sel_i]}
                                  : read_byte; // R06
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The watch clock comes from another domain; a change is accepted once
  // the second and third stages agree.
  logic w_s1;
  logic w_s2;
  logic w_s3;
  logic w_level;
  logic w_rise;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      w_s1 <= 1'b0;
      w_s2 <= 1'b0;
      w_s3 <= 1'b0;
      w_level <= 1'b0;
    end else begin
      w_s1 <= watch_clock_in_i;
      w_s2 <= w_s1;
      w_s3 <= w_s2;
      if (w_s2 == w_s3) begin
        w_level <= w_s3;
      end
    end
  end

  // Without watch clock edges the scan simply halts.
  assign w_rise = (w_s2 == w_s3) && w_s3 && !w_level; // R14

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] div_cnt;
  logic [7:0] div_last;
  logic [2:0] com_idx;
  logic [2:0] com_last;
  logic scan_tick;

  // Codes above the fastest one behave as the fastest.
  assign div_last = sld_div_last(lcd_control[SLD_CLK_LSB +: 3]); // R09 R10
  assign com_last = sld_com_last(lcd_control[SLD_DUTY_LSB +: 3]); // R11 R16
  assign scan_tick = w_rise && (div_cnt == div_last); // R09

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= 8'h00;
    end else if (ctrl_wr) begin
      div_cnt <= 8'h00; // R13
    end else if (scan_tick) begin
      div_cnt <= 8'h00;
    end else if (w_rise) begin
      div_cnt <= 8'(div_cnt + 8'h01); // R07
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      com_idx <= 3'h0;
    end else if (ctrl_wr) begin
      com_idx <= 3'h0; // R13
    end else if (scan_tick) begin
      com_idx <= (com_idx >= com_last) ? 3'h0 : 3'(com_idx + 3'h1); // R17 R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Panel drive, refreshed every cycle; in normal mode segments come from memory without processor help.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      common_drive_pins_o <= '0;
      segment_drive_pins_o <= '0;
      bias_sel_o <= 2'h0;
      scan_clock_o <= 1'b0;
    end else begin
      scan_clock_o <= scan_tick;
      bias_sel_o <= (lcd_control[SLD_DUTY_LSB +: 3] == 3'h0) ? 2'h0 :
                    (lcd_control[SLD_DUTY_LSB +: 3] == 3'h3) ? 2'h2 : 2'h1;
      common_drive_pins_o <= (mode == SLD_MODE_OFF) ? '0 :
                             COMS'(1) << com_idx; // R01 R16
      for (int s = 0; s < SEGS; s++) begin
        unique case (mode)
          SLD_MODE_OFF: segment_drive_pins_o[s] <= 1'b0; // R12
          SLD_MODE_BLANK: segment_drive_pins_o[s] <= 1'b0; // R12
          SLD_MODE_ALL: segment_drive_pins_o[s] <= 1'b1; // R12 R04
          SLD_MODE_NORMAL: segment_drive_pins_o[s] <= mem[s][com_idx]; // R03 R05
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_write_restart_scan: assert property ( // R13
    ctrl_wr |=> (div_cnt == 8'h00) && (com_idx == 3'h0))
    else $error("Control write did not restart the scan.");

  a_com_in_range: assert property ( // R16
    !$past(ctrl_wr) |-> com_idx <= com_last)
    else $error("Common index beyond the duty setting.");

  a_com_ascend: assert property ( // R17
    (scan_tick && !ctrl_wr && com_idx < com_last) |=>
      com_idx == 3'($past(com_idx) + 3'h1))
    else $error("Commons not visited in ascending order.");

  a_com_wrap: assert property ( // R15
    (scan_tick && !ctrl_wr && com_idx == com_last) |=> com_idx == 3'h0)
    else $error("Frame did not restart after the last common.");

  a_div_terminal: assert property ( // R09
    (w_rise && !ctrl_wr && div_cnt != div_last) |=>
      (div_cnt == 8'($past(div_cnt) + 8'h01)) && !scan_tick)
    else $error("Scan divider did not count a watch clock edge.");

  a_off_blank: assert property ( // R12
    (mode == SLD_MODE_OFF) |=>
      (common_drive_pins_o == '0) && (segment_drive_pins_o == '0))
    else $error("Panel driven while display is off.");

  a_force_select: assert property ( // R04
    (mode == SLD_MODE_ALL) |=> (segment_drive_pins_o == {SEGS{1'b1}}) &&
      (common_drive_pins_o == COMS'(1) << $past(com_idx)))
    else $error("All-on mode did not select every dot.");

  a_normal_data: assert property ( // R03
    (mode == SLD_MODE_NORMAL) |=>
      segment_drive_pins_o[SEGS-1] == $past(mem[SEGS-1][com_idx]))
    else $error("Segment does not follow its memory bit.");

  a_ram_readback: assert property ( // R06
    (ram_wr && !cpu_bit_op_i) ##1 (cpu_rd_i && !cpu_bit_op_i && ram_hit &&
      !cpu_wr_i && ram_idx == $past(ram_idx)) |=>
      cpu_rdata_o == $past(cpu_wdata_i, 2))
    else $error("Display memory byte did not read back.");

  c_normal_tick: cover property (mode == SLD_MODE_NORMAL && scan_tick);
  c_third_duty_wrap: cover property (com_last == 3'h2 && scan_tick &&
                                     com_idx == 3'h2);
  c_bit_write: cover property (ram_wr && cpu_bit_op_i);
  c_ctrl_restart: cover property (ctrl_wr && com_idx != 3'h0);

endmodule

// [rtl/sld_pkg.sv]
package sld_pkg;

  // Panel geometry.
  localparam int SLD_SEGS = 22;
  localparam int SLD_COMS = 8;

  // Register placement and reset value.
  localparam logic [7:0] SLD_CTRL_OFFSET = 8'hf9;
  localparam logic [7:0] SLD_CTRL_RESET = 8'h00;
  localparam logic [7:0] SLD_RAM_LAST = 8'h15;

  // Field positions inside the control register.
  localparam int SLD_CLK_LSB = 5;
  localparam int SLD_DUTY_LSB = 2;
  localparam int SLD_MODE_LSB = 0;

  // Fastest supported scan clock code, watch clock divided by 16.
  localparam logic [2:0] SLD_CODE_FASTEST = 3'h4;
  // Watch clock edges per scan clock at code 000.
  localparam logic [8:0] SLD_DIV_SLOWEST = 9'h100;

  typedef enum logic [1:0] {
    SLD_MODE_OFF,
    SLD_MODE_BLANK,
    SLD_MODE_ALL,
    SLD_MODE_NORMAL
  } sld_mode_t;

  // Terminal count of the scan clock divider for a clock select code.
  function automatic logic [7:0] sld_div_last(input logic [2:0] code);
    logic [2:0] c;
    c = (code > SLD_CODE_FASTEST) ? SLD_CODE_FASTEST : code;
    return 8'((SLD_DIV_SLOWEST >> c) - 9'h001);
  endfunction

  // Index of the last scanned common for a duty/bias code.
  function automatic logic [2:0] sld_com_last(input logic [2:0] duty);
    case (duty)
      3'h0: return 3'h7;
      3'h1: return 3'h3;
      3'h2, 3'h3: return 3'h2;
      default: return 3'h1;
    endcase
  endfunction

  // Byte or single-bit write merge.
  function automatic logic [7:0] sld_merge(input logic [7:0] old,
                                           input logic [7:0] wdata,
                                           input logic bit_op,
                                           input logic [2:0] bit_sel);
    logic [7:0] r;
    r = wdata;
    if (bit_op) begin
      r = old;
      r[bit_sel] = wdata[0];
    end
    return r;
  endfunction

endpackage

// [dv/sld_panel_model.sv]
`timescale 1ns/1ns

// Passive glass: remembers which commons were driven since a clear.
module sld_panel_model (
  input wire logic clk_i,
  input wire logic clear_i,
  input wire logic [7:0] common_drive_pins_i,
  output logic [7:0] com_seen_o
);
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      com_seen_o <= 8'h00;
    end else begin
      com_seen_o <= com_seen_o | common_drive_pins_i;
    end
  end
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ns

module testbench;
  import sld_pkg::*;
  logic clk_i = 0;
  logic reset_n_i = 0;
  logic watch = 0;
  logic wr = 0;
  logic rd = 0;
  logic sel = 0;
  logic bo = 0;
  logic clr = 1;
  logic [2:0] bs = 0;
  logic [7:0] addr = 0;
  logic [7:0] wd = 0;
  logic [7:0] rdata;
  logic [7:0] com;
  logic [7:0] seen;
  logic [21:0] seg;
  logic [1:0] bias;
  logic sclk;
  logic [7:0] mem [22];
  int n_errors = 0;
  int tests_run = 0;
  int n_sclk = 0;
  int k0;
  time ts;
  time t0;
  time t1;

  always #50 clk_i = ~clk_i;

  // The watch clock is kept off the system clock edges.
  initial begin
    #237;
    forever #500 watch = ~watch;
  end

  sld_segment_lcd_driver uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .watch_clock_in_i(watch), .cpu_wr_i(wr), .cpu_rd_i(rd),
    .cpu_ram_sel_i(sel), .cpu_addr_i(addr), .cpu_bit_op_i(bo),
    .cpu_bit_sel_i(bs), .cpu_wdata_i(wd), .cpu_rdata_o(rdata),
    .segment_drive_pins_o(seg), .common_drive_pins_o(com),
    .bias_sel_o(bias), .scan_clock_o(sclk));

  sld_panel_model panel (.clk_i(clk_i), .clear_i(clr),
    .common_drive_pins_i(com), .com_seen_o(seen));

  // Counts scan clock pulses as the panel side sees them.
  always @(posedge clk_i) begin
    if (sclk) begin
      n_sclk <= n_sclk + 1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic acc(input logic w, input logic s, input logic b,
                     input logic [2:0] k, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk_i);
    wr <= w;
    rd <= !w;
    sel <= s;
    bo <= b;
    bs <= k;
    addr <= a;
    wd <= d;
    @(posedge clk_i);
    wr <= 0;
    rd <= 0;
    #1;
  endtask

  // Write a byte and read it back on the very next cycle.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr <= 1;
    sel <= 1;
    bo <= 0;
    addr <= a;
    wd <= d;
    @(posedge clk_i);
    wr <= 0;
    rd <= 1;
    @(posedge clk_i);
    rd <= 0;
    #1;
  endtask

  task automatic ctrl(input logic [7:0] v);
    acc(1, 0, 0, 0, SLD_CTRL_OFFSET, v);
    ts = $time;
  endtask

  task automatic wait_chg(output time t);
    logic [7:0] c0;
    int i;
    c0 = com;
    for (i = 0; i < 6000 && com === c0; i++) @(posedge clk_i) #1;
    chk(i < 6000, 1);
    t = $time;
  endtask

  function automatic logic [21:0] row(int k);
    for (int n = 0; n < 22; n++) row[n] = mem[n][k];
  endfunction

  // True when a span lies within tol below to 200 ns above the period.
  function automatic logic near(time d, int c, int tol);
    return d > (256 >> c) * 1000 - tol && d < (256 >> c) * 1000 + 200;
  endfunction

  task automatic test_done;
    $display("Errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #5_000_000;
    n_errors++;
    test_done();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1;
    clr <= 0;
    acc(0, 0, 0, 0, SLD_CTRL_OFFSET, 0);
    chk(rdata, SLD_CTRL_RESET);
    chk(com, 0);
    for (int n = 0; n < 22; n++) begin
      mem[n] = 8'(n * 29) ^ 8'h5a;
      acc(1, 1, 0, 0, 8'(n), mem[n]);
    end
    acc(0, 1, 0, 0, 8'h15, 0);
    chk(rdata, mem[21]);
    acc(1, 1, 1, 3'h6, 8'h04, 8'h01);
    mem[4][6] = 1'b1;
    acc(0, 1, 1, 3'h6, 8'h04, 0);
    chk(rdata, 1);
    acc(0, 1, 0, 0, 8'h04, 0);
    chk(rdata, mem[4]);
    acc(0, 1, 0, 0, 8'h16, 0);
    chk(rdata, 0);
    mem[9] = 8'hc3;
    wr_rd(8'h09, mem[9]);
    chk(rdata, mem[9]);
    ctrl(8'h8b);
    @(posedge clk_i) #1;
    chk(com, 8'h01);
    for (int i = 1; i < 7; i++) begin
      wait_chg(t0);
      chk(com, 8'h01 << (i % 3));
      chk(seg, row(i % 3));
    end
    chk(seen, 8'h07);
    for (int d = 0; d < 4; d++) begin
      ctrl({3'h4, 3'(d), 2'b11});
      @(posedge clk_i);
      clr <= 1;
      @(posedge clk_i);
      clr <= 0;
      repeat (1700) @(posedge clk_i);
      chk(seen, d == 0 ? 8'hff : d == 1 ? 8'h0f : 8'h07);
      chk(bias, d == 0 ? 0 : d == 3 ? 2 : 1);
    end
    for (int c = 0; c < 5; c++) begin
      ctrl({3'(c), 3'h1, 2'b11});
      repeat (2) @(posedge clk_i);
      wait_chg(t0);
      k0 = n_sclk;
      wait_chg(t1);
      chk(near(t0 - ts, c, 1200), 1);
      chk(near(t1 - t0, c, 200), 1);
      chk(n_sclk - k0, 1);
    end
    ctrl(8'h8e);
    wait_chg(t0);
    chk(seg, 22'h3fffff);
    ctrl(8'h8d);
    wait_chg(t0);
    chk(seg, 0);
    chk(com !== 0, 1);
    ctrl(8'h8c);
    repeat (2) @(posedge clk_i);
    #1;
    chk({com, seg}, 0);
    acc(1, 0, 1, 3'h0, SLD_CTRL_OFFSET, 8'h01);
    acc(0, 0, 0, 0, SLD_CTRL_OFFSET, 0);
    chk(rdata, 8'h8d);
    reset_n_i <= 0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1;
    acc(0, 0, 0, 0, SLD_CTRL_OFFSET, 0);
    chk({rdata, com}, {SLD_CTRL_RESET, 8'h00});
    test_done();
  end
endmodule
